// ### logic/mspe_defs.vh
// Constants for the misalignment syndrome and program exception unit
`ifndef MSPE_DEFS_VH
`define MSPE_DEFS_VH

// ****************************************************************
// Syndrome field placement and prefixes
// ****************************************************************
`define MSPE_SYN_LSB      10
`define MSPE_SYN_MSB      16
`define MSPE_PFX_BASE     3'h0
`define MSPE_PFX_UPD      3'h1
`define MSPE_PFX_STR      3'h2
`define MSPE_PFX_BREV     3'h4
`define MSPE_PFX_XCTL     3'h5
`define MSPE_PFX_IDX      3'h6
`define MSPE_PFX_IDXU     3'h7

// ****************************************************************
// Syndrome low four bits by access type
// ****************************************************************
`define MSPE_LO_LW        4'h0
`define MSPE_LO_SW        4'h2
`define MSPE_LO_LHZ       4'h4
`define MSPE_LO_LHA       4'h5
`define MSPE_LO_STH       4'h6
`define MSPE_LO_MULT      4'h7
`define MSPE_LO_LFS       4'h8
`define MSPE_LO_STFS      4'hA
`define MSPE_LO_LWA       4'hD
`define MSPE_LO_LWAX      4'h5
`define MSPE_LO_STRX_L    4'h8
`define MSPE_LO_STRI_L    4'h9
`define MSPE_LO_STRX_S    4'hA
`define MSPE_LO_STRI_S    4'hB
`define MSPE_LO_BRW_L     4'h8
`define MSPE_LO_BRW_S     4'hA
`define MSPE_LO_BRH_L     4'hC
`define MSPE_LO_BRH_S     4'hE
`define MSPE_LO_XCTL_IN   4'h4
`define MSPE_LO_XCTL_OUT  4'h6
`define MSPE_LO_BLKZERO   4'hF
`define MSPE_LO_FPIW      4'hF

// ****************************************************************
// Instruction fields and opcodes
// ****************************************************************
`define MSPE_OP_RSVD0     6'h00
`define MSPE_OP_EXT       6'h1F
`define MSPE_OP_DSLOAD    6'h3A
`define MSPE_DS_LWA       2'h2
`define MSPE_SPR0_BIT     15

// ****************************************************************
// Vectors and saved-status type bits
// ****************************************************************
`define MSPE_VEC_HI_BASE  32'hFFF00000
`define MSPE_VEC_PROG     32'h00000700
`define MSPE_VEC_ALIGN    32'h00000600
`define MSPE_SS_FP        20
`define MSPE_SS_ILL       19
`define MSPE_SS_PRIV      18
`define MSPE_SS_TRAP      17

`endif

// ### logic/mspe_sticky_flag.v
// Sticky flag with set priority over clear
`timescale 1ns/1ps
module mspe_sticky_flag (
    input  wire clk,
    input  wire rstn,
    input  wire set,
    input  wire clr,
    output wire flag
);
    reg flag_reg;

    // Set wins when both arrive together
    always @(posedge clk)
    begin
        if (!rstn)
            flag_reg <= 1'b0;
        else if (set)
            flag_reg <= 1'b1;
        else if (clr)
            flag_reg <= 1'b0;
    end

    assign flag = flag_reg;
endmodule

// ### logic/mspe_top.v
// Alignment syndrome encoder and program exception detector
`timescale 1ns/1ps
`include "mspe_defs.vh"
module mspe_top (
    input  wire        CLK,
    input  wire        RSTN,
    input  wire        EXEC_VALID,
    input  wire [31:0] INSTR,
    input  wire [31:0] EFF_ADDR,
    input  wire        HIGHER_PENDING,
    input  wire        MISALIGN,
    input  wire        LITTLE_ENDIAN,
    input  wire        DIRECT_STORE,
    input  wire        ILLEGAL_OPCODE,
    input  wire        INVALID_CLASS,
    input  wire        LSWX_OVERLAP,
    input  wire        SPR_UNDEFINED,
    input  wire        PRIV_INSTR,
    input  wire        FP_UNIMPL,
    input  wire        TRAP_INSTR,
    input  wire [4:0]  TRAP_COND,
    input  wire [31:0] OPERAND_A,
    input  wire [31:0] OPERAND_B,
    input  wire        FP_ENABLED_EXC,
    input  wire        FPSCR_WRITE,
    input  wire [4:0]  FPSCR_EXC_BITS,
    input  wire [4:0]  FPSCR_EN_BITS,
    input  wire        FPSCR_CLEAR_SUMMARY,
    input  wire        FP_EXC_MODE_BIT0,
    input  wire        FP_EXC_MODE_BIT1,
    input  wire        USER_MODE_BIT,
    input  wire        VECTOR_BASE_SELECT,
    input  wire        CFG_LE_MISALIGN_EXC,
    input  wire        CFG_ILL_INVALID_CLASS,
    input  wire        CFG_ILL_LSWX,
    input  wire        CFG_ILL_SPR_UNDEF,
    input  wire        CFG_SPR_PRIV_AS_ILL,
    input  wire        CFG_FP_ASSIST,
    output wire        ALIGN_EXC,
    output wire        PROG_EXC,
    output wire        FP_ASSIST_EXC,
    output wire        LE_MISALIGN_DONE,
    output wire [31:0] EXC_VECTOR,
    output wire [31:0] MISALIGN_SYNDROME,
    output wire [31:0] FAULT_ADDRESS,
    output wire [31:0] SAVED_STATUS,
    output wire        FP_ENABLED_SUMMARY
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg        align_exc_reg;
    reg        prog_exc_reg;
    reg        fp_assist_reg;
    reg        le_done_reg;
    reg [31:0] vector_reg;
    reg [31:0] misalign_syndrome_reg;
    reg [31:0] fault_address_reg;
    reg [31:0] saved_status_reg;
    reg [31:0] vector_next;
    reg [31:0] status_next;
    reg [2:0]  syn_pfx;
    reg [3:0]  syn_lo;
    reg        syn_valid;
    reg        syn_fp;
    wire [5:0] op;
    wire [9:0] xo;
    wire       spr_hi;
    wire       trap_hit;
    wire       fp_enabled_summary_flag;
    wire       fpscr_sets_summary;
    wire       cond_fp;
    wire       cond_ill;
    wire       cond_priv;
    wire       cond_trap;
    wire       spr_priv;
    wire       spr_ill;
    wire       fp_assist;
    wire       prog_any;
    wire       align_fault;
    wire       take_ok;
    wire [31:0] vec_base;

    assign op     = INSTR[31:26];
    assign xo     = INSTR[10:1];
    assign spr_hi = INSTR[`MSPE_SPR0_BIT];

    // ****************************************************************
    // Syndrome class encoder
    // ****************************************************************
    // Maps the executing instruction to prefix and low field
    always @*
    begin
        syn_pfx   = `MSPE_PFX_BASE;
        syn_lo    = `MSPE_LO_LW;
        syn_valid = 1'b0;
        syn_fp    = 1'b0;
        if (op == `MSPE_OP_RSVD0)
        begin
            syn_valid = 1'b1;
        end
        else if (op[5:4] == 2'h2 || op[5:3] == 3'h6)
        begin
            // Displacement forms, update selected by low opcode bit
            syn_pfx   = {2'h0, op[0]};
            syn_valid = 1'b1;
            case (op[4:1])
                4'h0: syn_lo = `MSPE_LO_LW;
                4'h2: syn_lo = `MSPE_LO_SW;
                4'h4: syn_lo = `MSPE_LO_LHZ;
                4'h5: syn_lo = `MSPE_LO_LHA;
                4'h6: syn_lo = `MSPE_LO_STH;
                4'h7: syn_lo = `MSPE_LO_MULT;
                4'h8:
                begin
                    syn_lo = `MSPE_LO_LFS;
                    syn_fp = 1'b1;
                end
                4'hA:
                begin
                    syn_lo = `MSPE_LO_STFS;
                    syn_fp = 1'b1;
                end
                default: syn_valid = 1'b0;
            endcase
        end
        else if (op == `MSPE_OP_DSLOAD && INSTR[1:0] == `MSPE_DS_LWA)
        begin
            syn_lo    = `MSPE_LO_LWA;
            syn_valid = 1'b1;
        end
        else if (op == `MSPE_OP_EXT)
        begin
            syn_valid = 1'b1;
            case (xo)
                10'h014: syn_lo = `MSPE_LO_LW;
                10'h017: {syn_pfx, syn_lo} = {`MSPE_PFX_IDX, `MSPE_LO_LW};
                10'h037: {syn_pfx, syn_lo} = {`MSPE_PFX_IDXU, `MSPE_LO_LW};
                10'h097: {syn_pfx, syn_lo} = {`MSPE_PFX_IDX, `MSPE_LO_SW};
                10'h0B7: {syn_pfx, syn_lo} = {`MSPE_PFX_IDXU, `MSPE_LO_SW};
                10'h117: {syn_pfx, syn_lo} = {`MSPE_PFX_IDX, `MSPE_LO_LHZ};
                10'h137: {syn_pfx, syn_lo} = {`MSPE_PFX_IDXU, `MSPE_LO_LHZ};
                10'h157: {syn_pfx, syn_lo} = {`MSPE_PFX_IDX, `MSPE_LO_LHA};
                10'h177: {syn_pfx, syn_lo} = {`MSPE_PFX_IDXU, `MSPE_LO_LHA};
                10'h197: {syn_pfx, syn_lo} = {`MSPE_PFX_IDX, `MSPE_LO_STH};
                10'h1B7: {syn_pfx, syn_lo} = {`MSPE_PFX_IDXU, `MSPE_LO_STH};
                10'h155: {syn_pfx, syn_lo} = {`MSPE_PFX_STR, `MSPE_LO_LWAX};
                10'h215: {syn_pfx, syn_lo} = {`MSPE_PFX_STR, `MSPE_LO_STRX_L};
                10'h255: {syn_pfx, syn_lo} = {`MSPE_PFX_STR, `MSPE_LO_STRI_L};
                10'h295: {syn_pfx, syn_lo} = {`MSPE_PFX_STR, `MSPE_LO_STRX_S};
                10'h2D5: {syn_pfx, syn_lo} = {`MSPE_PFX_STR, `MSPE_LO_STRI_S};
                10'h096: {syn_pfx, syn_lo} = {`MSPE_PFX_BREV, `MSPE_LO_SW};
                10'h216: {syn_pfx, syn_lo} = {`MSPE_PFX_BREV, `MSPE_LO_BRW_L};
                10'h296: {syn_pfx, syn_lo} = {`MSPE_PFX_BREV, `MSPE_LO_BRW_S};
                10'h316: {syn_pfx, syn_lo} = {`MSPE_PFX_BREV, `MSPE_LO_BRH_L};
                10'h396: {syn_pfx, syn_lo} = {`MSPE_PFX_BREV, `MSPE_LO_BRH_S};
                10'h136: {syn_pfx, syn_lo} = {`MSPE_PFX_XCTL, `MSPE_LO_XCTL_IN};
                10'h1B6: {syn_pfx, syn_lo} = {`MSPE_PFX_XCTL, `MSPE_LO_XCTL_OUT};
                10'h3F6: {syn_pfx, syn_lo} = {`MSPE_PFX_XCTL, `MSPE_LO_BLKZERO};
                10'h217:
                begin
                    {syn_pfx, syn_lo} = {`MSPE_PFX_IDX, `MSPE_LO_LFS};
                    syn_fp = 1'b1;
                end
                10'h237:
                begin
                    {syn_pfx, syn_lo} = {`MSPE_PFX_IDXU, `MSPE_LO_LFS};
                    syn_fp = 1'b1;
                end
                10'h297:
                begin
                    {syn_pfx, syn_lo} = {`MSPE_PFX_IDX, `MSPE_LO_STFS};
                    syn_fp = 1'b1;
                end
                10'h2B7:
                begin
                    {syn_pfx, syn_lo} = {`MSPE_PFX_IDXU, `MSPE_LO_STFS};
                    syn_fp = 1'b1;
                end
                10'h3D7:
                begin
                    {syn_pfx, syn_lo} = {`MSPE_PFX_IDX, `MSPE_LO_FPIW};
                    syn_fp = 1'b1;
                end
                default: syn_valid = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Floating-point summary flag and trap compare
    // ****************************************************************
    // Status write sets summary when an enabled exception bit is set
    assign fpscr_sets_summary = FPSCR_WRITE & (|(FPSCR_EXC_BITS & FPSCR_EN_BITS));

    mspe_sticky_flag u_fp_summary (
        .clk  (CLK),
        .rstn (RSTN),
        .set  (FP_ENABLED_EXC | fpscr_sets_summary),
        .clr  (FPSCR_CLEAR_SUMMARY),
        .flag (fp_enabled_summary_flag)
    );

    mspe_trap_cmp u_trap (
        .cond (TRAP_COND),
        .a    (OPERAND_A),
        .b    (OPERAND_B),
        .hit  (trap_hit)
    );

    // ****************************************************************
    // Program exception conditions
    // ****************************************************************
    // Enabled float exception needs summary and a mode bit
    assign cond_fp   = fp_enabled_summary_flag & (FP_EXC_MODE_BIT0 | FP_EXC_MODE_BIT1);

    // Undefined SPR number split by user mode and high bit
    assign spr_priv  = SPR_UNDEFINED & USER_MODE_BIT & spr_hi & ~CFG_SPR_PRIV_AS_ILL;
    assign spr_ill   = SPR_UNDEFINED & ((USER_MODE_BIT & spr_hi & CFG_SPR_PRIV_AS_ILL)
                     | (~(USER_MODE_BIT & spr_hi) & CFG_ILL_SPR_UNDEF));

    // Unimplemented float op goes to assist when enabled
    assign fp_assist = FP_UNIMPL & CFG_FP_ASSIST;

    // Illegal opcode plus the optional illegal cases
    assign cond_ill  = ILLEGAL_OPCODE | (FP_UNIMPL & ~CFG_FP_ASSIST)
                     | (INVALID_CLASS & CFG_ILL_INVALID_CLASS)
                     | (LSWX_OVERLAP & CFG_ILL_LSWX) | spr_ill;

    assign cond_priv = (PRIV_INSTR & USER_MODE_BIT) | spr_priv;
    assign cond_trap = TRAP_INSTR & trap_hit;
    assign prog_any  = cond_fp | cond_ill | cond_priv | cond_trap;

    // Only when nothing of higher priority is pending
    assign take_ok   = EXEC_VALID & ~HIGHER_PENDING;

    // ****************************************************************
    // Alignment fault qualification
    // ****************************************************************
    // Little-endian misalignment traps only when configured
    assign align_fault = syn_valid & ((MISALIGN & (~LITTLE_ENDIAN | CFG_LE_MISALIGN_EXC))
                       | (DIRECT_STORE & syn_fp));

    // Vector base chosen by the base select bit
    assign vec_base = VECTOR_BASE_SELECT ? `MSPE_VEC_HI_BASE : 32'h00000000;

    // ****************************************************************
    // Saved status and vector selection
    // ****************************************************************
    // One type bit only, float first then illegal, privileged, trap
    always @*
    begin
        status_next = 32'h00000000;
        vector_next = vec_base | `MSPE_VEC_ALIGN;
        if (prog_any)
        begin
            vector_next = vec_base | `MSPE_VEC_PROG;
            if (cond_fp)
                status_next[`MSPE_SS_FP] = 1'b1;
            else if (cond_ill)
                status_next[`MSPE_SS_ILL] = 1'b1;
            else if (cond_priv)
                status_next[`MSPE_SS_PRIV] = 1'b1;
            else
                status_next[`MSPE_SS_TRAP] = 1'b1;
        end
    end

    // ****************************************************************
    // Exception capture registers
    // ****************************************************************
    // Program first, then assist, then alignment
    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            align_exc_reg         <= 1'b0;
            prog_exc_reg          <= 1'b0;
            fp_assist_reg         <= 1'b0;
            le_done_reg           <= 1'b0;
            vector_reg            <= 32'h00000000;
            misalign_syndrome_reg <= 32'h00000000;
            fault_address_reg     <= 32'h00000000;
            saved_status_reg      <= 32'h00000000;
        end
        else
        begin
            align_exc_reg <= 1'b0;
            prog_exc_reg  <= 1'b0;
            fp_assist_reg <= 1'b0;
            le_done_reg   <= 1'b0;
            if (take_ok && prog_any)
            begin
                prog_exc_reg     <= 1'b1;
                vector_reg       <= vector_next;
                saved_status_reg <= status_next;
            end
            else if (take_ok && fp_assist)
            begin
                fp_assist_reg <= 1'b1;
            end
            else if (take_ok && align_fault)
            begin
                align_exc_reg     <= 1'b1;
                vector_reg        <= vector_next;
                fault_address_reg <= EFF_ADDR;
                misalign_syndrome_reg <= 32'h00000000;
                misalign_syndrome_reg[`MSPE_SYN_MSB:`MSPE_SYN_LSB] <= {syn_pfx, syn_lo};
            end
            else if (take_ok && MISALIGN && LITTLE_ENDIAN)
            begin
                le_done_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign ALIGN_EXC          = align_exc_reg;
    assign PROG_EXC           = prog_exc_reg;
    assign FP_ASSIST_EXC      = fp_assist_reg;
    assign LE_MISALIGN_DONE   = le_done_reg;
    assign EXC_VECTOR         = vector_reg;
    assign MISALIGN_SYNDROME  = misalign_syndrome_reg;
    assign FAULT_ADDRESS      = fault_address_reg;
    assign SAVED_STATUS       = saved_status_reg;
    assign FP_ENABLED_SUMMARY = fp_enabled_summary_flag;
endmodule

// ### logic/mspe_trap_cmp.v
// Trap condition evaluation for two operands
`timescale 1ns/1ps
module mspe_trap_cmp (
    input  wire [4:0]  cond,
    input  wire [31:0] a,
    input  wire [31:0] b,
    output wire        hit
);
    wire lt_s;
    wire gt_s;
    wire eq;
    wire lt_u;
    wire gt_u;

    // Signed, equal and unsigned compares
    assign lt_s = $signed(a) < $signed(b);
    assign gt_s = $signed(a) > $signed(b);
    assign eq   = a == b;
    assign lt_u = a < b;
    assign gt_u = a > b;

    // Any selected condition that holds is a hit
    assign hit = (cond[4] & lt_s) | (cond[3] & gt_s) | (cond[2] & eq)
               | (cond[1] & lt_u) | (cond[0] & gt_u);
endmodule

// ### sim/mspe_props.sv
// Concurrent checks on the syndrome and program exception unit ports
`timescale 1ns/1ps
module mspe_props (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        EXEC_VALID,
    input wire logic        HIGHER_PENDING,
    input wire logic        ILLEGAL_OPCODE,
    input wire logic        PRIV_INSTR,
    input wire logic        USER_MODE_BIT,
    input wire logic        TRAP_INSTR,
    input wire logic [4:0]  TRAP_COND,
    input wire logic [31:0] OPERAND_A,
    input wire logic [31:0] OPERAND_B,
    input wire logic [31:0] EFF_ADDR,
    input wire logic        FP_ENABLED_EXC,
    input wire logic        FPSCR_WRITE,
    input wire logic [4:0]  FPSCR_EXC_BITS,
    input wire logic [4:0]  FPSCR_EN_BITS,
    input wire logic        FP_EXC_MODE_BIT0,
    input wire logic        FP_EXC_MODE_BIT1,
    input wire logic        VECTOR_BASE_SELECT,
    input wire logic        ALIGN_EXC,
    input wire logic        PROG_EXC,
    input wire logic        FP_ASSIST_EXC,
    input wire logic        LE_MISALIGN_DONE,
    input wire logic [31:0] EXC_VECTOR,
    input wire logic [31:0] MISALIGN_SYNDROME,
    input wire logic [31:0] FAULT_ADDRESS,
    input wire logic [31:0] SAVED_STATUS,
    input wire logic        FP_ENABLED_SUMMARY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    wire go = EXEC_VALID && !HIGHER_PENDING;

    // ****************************************************************
    // Answer timing, selection and content
    // ****************************************************************
    one_answer_a: assert property ($onehot0({ALIGN_EXC, PROG_EXC, FP_ASSIST_EXC, LE_MISALIGN_DONE}))
        else $error("more than one answer pulse");
    blocked_exec_a: assert property (!go |=> !(ALIGN_EXC || PROG_EXC || FP_ASSIST_EXC || LE_MISALIGN_DONE))
        else $error("answer without a taken instruction");
    prog_vector_a: assert property (PROG_EXC |-> EXC_VECTOR == ($past(VECTOR_BASE_SELECT) ? 32'hFFF00700 : 32'h00000700))
        else $error("program vector wrong");
    one_type_a: assert property (PROG_EXC |-> $onehot(SAVED_STATUS) && SAVED_STATUS[20:17] != 4'h0)
        else $error("saved status type bits wrong");
    priv_user_a: assert property (go && PRIV_INSTR && USER_MODE_BIT |=> PROG_EXC)
        else $error("privileged in user mode not raised");
    trap_hit_a: assert property (go && TRAP_INSTR && TRAP_COND[2] && OPERAND_A == OPERAND_B |=> PROG_EXC)
        else $error("trap condition not raised");
    illegal_op_a: assert property (go && ILLEGAL_OPCODE |=> PROG_EXC)
        else $error("illegal opcode not raised");
    fp_enabled_a: assert property (go && FP_ENABLED_SUMMARY && (FP_EXC_MODE_BIT0 || FP_EXC_MODE_BIT1)
        |=> PROG_EXC && SAVED_STATUS[20])
        else $error("float enabled exception not raised");
    summary_set_a: assert property (FP_ENABLED_EXC || (FPSCR_WRITE && |(FPSCR_EXC_BITS & FPSCR_EN_BITS))
        |=> FP_ENABLED_SUMMARY)
        else $error("summary flag not set");
    syn_frame_a: assert property (ALIGN_EXC |-> MISALIGN_SYNDROME[31:17] == 15'h0000 && MISALIGN_SYNDROME[9:0] == 10'h000
        && FAULT_ADDRESS == $past(EFF_ADDR))
        else $error("syndrome frame or fault address wrong");

    // Main scenarios reached
    cov_align: cover property (ALIGN_EXC);
    cov_prog: cover property (PROG_EXC && SAVED_STATUS[20]);
    cov_le: cover property (LE_MISALIGN_DONE);
endmodule

bind mspe_top mspe_props u_props (.CLK(CLK), .RSTN(RSTN), .EXEC_VALID(EXEC_VALID), .HIGHER_PENDING(HIGHER_PENDING),
    .ILLEGAL_OPCODE(ILLEGAL_OPCODE), .PRIV_INSTR(PRIV_INSTR), .USER_MODE_BIT(USER_MODE_BIT), .TRAP_INSTR(TRAP_INSTR),
    .TRAP_COND(TRAP_COND), .OPERAND_A(OPERAND_A), .OPERAND_B(OPERAND_B), .EFF_ADDR(EFF_ADDR),
    .FP_ENABLED_EXC(FP_ENABLED_EXC), .FPSCR_WRITE(FPSCR_WRITE), .FPSCR_EXC_BITS(FPSCR_EXC_BITS),
    .FPSCR_EN_BITS(FPSCR_EN_BITS), .FP_EXC_MODE_BIT0(FP_EXC_MODE_BIT0), .FP_EXC_MODE_BIT1(FP_EXC_MODE_BIT1),
    .VECTOR_BASE_SELECT(VECTOR_BASE_SELECT), .ALIGN_EXC(ALIGN_EXC), .PROG_EXC(PROG_EXC), .FP_ASSIST_EXC(FP_ASSIST_EXC),
    .LE_MISALIGN_DONE(LE_MISALIGN_DONE), .EXC_VECTOR(EXC_VECTOR), .MISALIGN_SYNDROME(MISALIGN_SYNDROME),
    .FAULT_ADDRESS(FAULT_ADDRESS), .SAVED_STATUS(SAVED_STATUS), .FP_ENABLED_SUMMARY(FP_ENABLED_SUMMARY));

// ### sim/testbench.sv
// Self-checking bench for the syndrome and program exception unit
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rstn = 1'b0, exec_valid = 1'b0, vbs = 1'b0, fe0 = 1'b0, fe1 = 1'b0;
    logic fpx = 1'b0, fpw = 1'b0, fpclr = 1'b0;
    logic [11:0] flg = 12'h000;
    logic [5:0] cfg = 6'h00;
    logic [4:0] tcond = 5'h00, fexc = 5'h00, fen = 5'h00;
    logic [31:0] instr = 32'h0, addr = 32'h0, opa = 32'h0, opb = 32'h0;
    logic [98:0] expq[$];
    logic [98:0] e;
    logic [2:0] ok;
    logic [31:0] ti[18], p;
    logic [6:0] tc[18];
    wire w_al, w_pr, w_as, w_le, w_sum;
    wire [31:0] w_vec, w_syn, w_fa, w_ss;
    int failures = 0, cmp_count = 0, cyc = 0, i;
    localparam logic [11:0] F_HP = 12'h800, F_USR = 12'h400, F_MIS = 12'h200, F_LE = 12'h100, F_DS = 12'h080;
    localparam logic [11:0] F_ILL = 12'h040, F_PRV = 12'h020, F_TRP = 12'h010, F_SPR = 12'h008, F_FPU = 12'h004;
    localparam logic [11:0] F_INV = 12'h002;

    mspe_top dut (.CLK(clk), .RSTN(rstn), .EXEC_VALID(exec_valid), .INSTR(instr), .EFF_ADDR(addr),
        .HIGHER_PENDING(flg[11]), .USER_MODE_BIT(flg[10]), .MISALIGN(flg[9]), .LITTLE_ENDIAN(flg[8]),
        .DIRECT_STORE(flg[7]), .ILLEGAL_OPCODE(flg[6]), .PRIV_INSTR(flg[5]), .TRAP_INSTR(flg[4]),
        .SPR_UNDEFINED(flg[3]), .FP_UNIMPL(flg[2]), .INVALID_CLASS(flg[1]), .LSWX_OVERLAP(flg[0]),
        .TRAP_COND(tcond), .OPERAND_A(opa), .OPERAND_B(opb), .FP_ENABLED_EXC(fpx), .FPSCR_WRITE(fpw),
        .FPSCR_EXC_BITS(fexc), .FPSCR_EN_BITS(fen), .FPSCR_CLEAR_SUMMARY(fpclr), .FP_EXC_MODE_BIT0(fe0),
        .FP_EXC_MODE_BIT1(fe1), .VECTOR_BASE_SELECT(vbs), .CFG_LE_MISALIGN_EXC(cfg[5]),
        .CFG_ILL_INVALID_CLASS(cfg[4]), .CFG_ILL_LSWX(cfg[3]), .CFG_ILL_SPR_UNDEF(cfg[2]),
        .CFG_SPR_PRIV_AS_ILL(cfg[1]), .CFG_FP_ASSIST(cfg[0]), .ALIGN_EXC(w_al), .PROG_EXC(w_pr),
        .FP_ASSIST_EXC(w_as), .LE_MISALIGN_DONE(w_le), .EXC_VECTOR(w_vec), .MISALIGN_SYNDROME(w_syn),
        .FAULT_ADDRESS(w_fa), .SAVED_STATUS(w_ss), .FP_ENABLED_SUMMARY(w_sum));

    // ****************************************************************
    // Clock, timeout, compare and verdict
    // ****************************************************************
    always #25 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            failures++;
            stop_test;
        end
    end

    // Issues one instruction; kind 1 align, 2 program, 3 LE done, 4 assist
    task automatic go(input logic [31:0] ins, input logic [11:0] f, input logic [2:0] k, input logic [31:0] d);
        logic [31:0] a;
        logic b;
        a = $urandom;
        b = $urandom;
        @(posedge clk);
        instr <= ins;
        flg <= f;
        addr <= a;
        vbs <= b;
        exec_valid <= 1'b1;
        if (k != 3'h0)
            expq.push_back({k, (b ? 32'hFFF00000 : 32'h0) | (k == 3'h1 ? 32'h600 : 32'h700), d, a});
        @(posedge clk);
        exec_valid <= 1'b0;
        flg <= 12'h000;
    endtask

    // Monitor: each answer pulse takes the oldest note
    always @(negedge clk)
        if (rstn && (w_al || w_pr || w_le || w_as))
        begin
            ok = w_al ? 3'h1 : w_pr ? 3'h2 : w_le ? 3'h3 : 3'h4;
            if (expq.size() == 0)
                check({29'h0, ok}, 32'h0);
            else
            begin
                e = expq.pop_front();
                check({29'h0, ok}, {29'h0, e[98:96]});
                if (ok == 3'h1 || ok == 3'h2)
                    check(w_vec, e[95:64]);
                if (ok == 3'h1)
                begin
                    check(w_syn, e[63:32]);
                    check(w_fa, e[31:0]);
                end
                if (ok == 3'h2)
                    check(w_ss, e[63:32]);
            end
        end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        ti = '{32'h80000000, 32'h90000000, 32'hA0000000, 32'h84000000, 32'hB8000000, 32'hBC000000, 32'hC0000000,
               32'h7C00002E, 32'h7C00006E, 32'h7C00042C, 32'h7C00012D, 32'h7C000028, 32'h7C0007EC, 32'h7C00026C,
               32'h7C0007AE, 32'h7C00042A, 32'h00000000, 32'h7C0002AA};
        tc = '{7'h00, 7'h02, 7'h04, 7'h10, 7'h07, 7'h17, 7'h08, 7'h60, 7'h70, 7'h48, 7'h42, 7'h00, 7'h5F, 7'h54,
               7'h6F, 7'h28, 7'h00, 7'h25};
        p = 32'h7C000000;
        void'($urandom(6));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        // Syndrome encoding of 18 classes from the table, big-endian
        for (i = 0; i < 18; i++)
            go(ti[i], F_MIS, 3'h1, {15'h0, tc[i], 10'h0});
        go(ti[6], F_DS, 3'h1, {15'h0, 7'h08, 10'h0});
        go(ti[0], F_MIS | F_LE, 3'h3, 32'h0);
        cfg <= 6'h20;
        go(ti[0], F_MIS | F_LE, 3'h1, 32'h0);
        // Program conditions and their type bits
        go(p, F_ILL, 3'h2, 32'h1 << 19);
        go(p, F_ILL | F_HP, 3'h0, 32'h0);
        go(ti[0], F_ILL | F_MIS, 3'h2, 32'h1 << 19);
        go(p, F_PRV | F_USR, 3'h2, 32'h1 << 18);
        go(p, F_PRV, 3'h0, 32'h0);
        go(p | 32'h8000, F_SPR | F_USR, 3'h2, 32'h1 << 18);
        cfg <= 6'h13;
        go(p | 32'h8000, F_SPR | F_USR, 3'h2, 32'h1 << 19);
        go(p, F_INV, 3'h2, 32'h1 << 19);
        go(p, F_FPU, 3'h4, 32'h0);
        cfg <= 6'h00;
        go(p, F_FPU, 3'h2, 32'h1 << 19);
        // Optional illegal cases: string overlap and undefined SPR outside user mode
        cfg <= 6'h0C;
        go(p, 12'h001, 3'h2, 32'h1 << 19);
        go(p | 32'h8000, F_SPR, 3'h2, 32'h1 << 19);
        opa <= $urandom;
        tcond <= 5'h04;
        @(posedge clk);
        opb <= opa;
        go(p, F_TRP, 3'h2, 32'h1 << 17);
        opb <= ~opa;
        go(p, F_TRP, 3'h0, 32'h0);
        // Float enabled summary: set by float op, by status write, not by disjoint bits
        fpx <= 1'b1;
        @(posedge clk);
        fpx <= 1'b0;
        fe0 <= opa[0];
        fe1 <= ~opa[0];
        @(negedge clk);
        check({31'h0, w_sum}, 32'h1);
        go(p, F_TRP, 3'h2, 32'h1 << 20);
        fpclr <= 1'b1;
        fexc <= 5'h0A;
        fen <= 5'h15;
        fpw <= 1'b1;
        @(posedge clk);
        fpclr <= 1'b0;
        fexc <= 5'h10;
        fen <= 5'h1F;
        @(negedge clk);
        check({31'h0, w_sum}, 32'h0);
        @(posedge clk);
        fpw <= 1'b0;
        @(negedge clk);
        check({31'h0, w_sum}, 32'h1);
        repeat (3) @(posedge clk);
        check(expq.size(), 32'h0);
        stop_test;
    end
endmodule
